/* rtl/alm_pkg.sv */
// Purpose: Shared constants and types for the async list bitmaps and mode register
// Assumes: 32-bit word registers on a simple synchronous processor port
// Notes:   Byte offsets are printed as word-aligned addresses
package alm_pkg;
  localparam int          SLOTS          = 32;            // Descriptor slots per list
  localparam logic [11:0] OFS_DONE       = 12'h150;       // Done bitmap
  localparam logic [11:0] OFS_SKIP       = 12'h154;       // Skip bitmap
  localparam logic [11:0] OFS_FINAL      = 12'h158;       // Final slot bitmap
  localparam logic [11:0] OFS_HWMODE     = 12'h300;       // Hardware mode config
  localparam logic [31:0] RST_DONE       = 32'h00000000;
  localparam logic [31:0] RST_SKIP       = 32'hffffffff;  // Every slot skipped at start
  localparam logic [31:0] RST_FINAL      = 32'h00000000;
  localparam logic [31:0] RST_HWMODE     = 32'h00000100;  // 32-bit bus after reset
  localparam logic [31:0] HWMODE_MASK    = 32'h80008167;  // Implemented mode bits
  localparam int          B_XCVR_RST     = 31;            // All transceiver reset
  localparam int          B_OC_TYPE      = 15;            // Overcurrent type select
  localparam int          B_BUS_WIDTH    = 8;             // 1 = 32-bit, 0 = 16-bit
  localparam int          B_DMA_ACK_POLARITY     = 6;             // DMA ack polarity
  localparam int          B_DMA_REQUEST_POLARITY     = 5;             // DMA request polarity
  localparam int          B_IRQ_POL      = 2;             // Irq polarity
  localparam int          B_IRQ_TRIG     = 1;             // 0 level, 1 pulse
  localparam int          B_IRQ_EN       = 0;             // Irq master enable
  localparam int          CLK_PERIOD_NS  = 5;             // 200 MHz reference clock
  localparam int          IRQ_PULSE_NS   = 50;            // Width of pulse-mode interrupt
  localparam int          IRQ_PULSE_CYC  = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Processor port request, one cycle strobes
  typedef struct packed {
    logic        sel;    // Chip select
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
    logic [11:0] addr;   // Byte address
    logic [31:0] wdata;  // Write data
  } alm_bus_req_t;

  // Scanner states, Gray coded along idle-scan-exec
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_EXEC = 2'b11
  } alm_state_t;
endpackage

/* rtl/alm_async_list_maps.sv */
// Purpose: Async list done/skip/final bitmaps, slot scanner and hardware mode register
// Assumes: Engine reports completion of the started slot with a one-cycle pulse
// Notes:   Read data appears one cycle after the read strobe
module alm_async_list_maps #(
  parameter int IRQ_PULSE = alm_pkg::IRQ_PULSE_CYC  // Pulse-mode width in cycles
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire alm_pkg::alm_bus_req_t bus_req,              // Processor request
  output logic [31:0]                bus_rdata_q,          // Read data
  output logic                       bus_rvalid_q,         // Read data valid pulse
  input  wire logic                  sched_enable,         // Scanner run enable
  input  wire logic [31:0]           slot_valid,           // Valid flag of each slot
  output logic                       sched_start_q,        // Start pulse to engine
  output logic [4:0]                 sched_slot_q,         // Slot being executed
  input  wire logic                  exec_done,            // Engine completion pulse
  input  wire logic                  irq_event,            // Interrupt cause, level
  output logic                       irq_out_q,            // Interrupt pin level
  input  wire logic                  dma_ack_input,        // Raw DMA ack pin
  output logic                       dma_ack_active_q,     // Ack, active high inside
  input  wire logic                  dma_req,              // Internal DMA request
  output logic                       dma_request_output_q, // DMA request pin level
  output logic                       all_transceiver_reset_q,
  output logic                       overcurrent_type_select_q,
  output logic                       bus_is_32bit_q        // Selects processor bus width
);
  logic [31:0]         done_q, done_d;     // Done bitmap
  logic [31:0]         skip_q, skip_d;     // Skip bitmap
  logic [31:0]         final_q, final_d;   // Final slot bitmap
  logic [31:0]         mode_q, mode_d;     // Hardware mode bits
  logic [31:0]         rdata_d;
  logic                rvalid_d;
  alm_pkg::alm_state_t st_q, st_d;         // Scanner state
  logic [4:0]          idx_q, idx_d;       // Slot under examination
  logic                start_d;
  logic [4:0]          slot_d;
  logic [7:0]          pcnt_q, pcnt_d;     // Pulse counter
  logic                evt_q;              // Previous irq_event
  logic                irq_d, ack_d, dma_request_output_d;
  logic                hit_done, hit_skip, hit_final, hit_mode, rd_done;

  // Next slot after idx: wrap at final bit or at the top slot
  function automatic logic [4:0] next_slot(input logic [4:0] i, input logic [31:0] fin);
    next_slot = (fin[i] || i == 5'h1f) ? 5'h00 : i + 5'h01;
  endfunction

  assign hit_done  = bus_req.sel && bus_req.addr == alm_pkg::OFS_DONE;
  assign hit_skip  = bus_req.sel && bus_req.addr == alm_pkg::OFS_SKIP;
  assign hit_final = bus_req.sel && bus_req.addr == alm_pkg::OFS_FINAL;
  assign hit_mode  = bus_req.sel && bus_req.addr == alm_pkg::OFS_HWMODE;
  assign rd_done   = hit_done && bus_req.rd;

  // Register file next values
  always_comb begin
    skip_d   = skip_q;
    final_d  = final_q;
    mode_d   = mode_q;
    rdata_d  = bus_rdata_q;
    rvalid_d = bus_req.sel && bus_req.rd;
    // Clear what was read, then apply completions so a coinciding set survives
    done_d = rd_done ? 32'h00000000 : done_q;
    if (st_q == alm_pkg::ST_EXEC && exec_done) begin
      done_d[sched_slot_q] = 1'b1;
    end
    if (bus_req.sel && bus_req.wr) begin
      // Done map ignores writes
      if (hit_skip)  skip_d  = bus_req.wdata;
      if (hit_final) final_d = bus_req.wdata;
      // Reserved bits are not stored, so they read back zero
      if (hit_mode)  mode_d  = bus_req.wdata & alm_pkg::HWMODE_MASK;
    end
    if (bus_req.sel && bus_req.rd) begin
      if (hit_done)       rdata_d = done_q;
      else if (hit_skip)  rdata_d = skip_q;
      else if (hit_final) rdata_d = final_q;
      else if (hit_mode)  rdata_d = mode_q;
      else                rdata_d = 32'h00000000;  // Unmapped reads zero
    end
  end

  // Register file storage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      done_q       <= alm_pkg::RST_DONE;
      skip_q       <= alm_pkg::RST_SKIP;
      final_q      <= alm_pkg::RST_FINAL;
      mode_q       <= alm_pkg::RST_HWMODE;
      bus_rdata_q  <= 32'h00000000;
      bus_rvalid_q <= 1'b0;
    end else begin
      done_q       <= done_d;
      skip_q       <= skip_d;
      final_q      <= final_d;
      mode_q       <= mode_d;
      bus_rdata_q  <= rdata_d;
      bus_rvalid_q <= rvalid_d;
    end
  end

  assign all_transceiver_reset_q   = mode_q[alm_pkg::B_XCVR_RST];
  assign overcurrent_type_select_q = mode_q[alm_pkg::B_OC_TYPE];
  assign bus_is_32bit_q            = mode_q[alm_pkg::B_BUS_WIDTH];

  // Scanner: walks slots by index only; descriptor contents never steer the order
  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    start_d = 1'b0;
    slot_d  = sched_slot_q;
    unique case (st_q)
      alm_pkg::ST_IDLE: begin
        if (sched_enable) st_d = alm_pkg::ST_SCAN;
      end
      alm_pkg::ST_SCAN: begin
        if (!sched_enable) begin
          st_d = alm_pkg::ST_IDLE;
        end else if (slot_valid[idx_q] && !skip_q[idx_q]) begin
          start_d = 1'b1;
          slot_d  = idx_q;
          st_d    = alm_pkg::ST_EXEC;
        end else begin
          idx_d = next_slot(idx_q, final_q);
        end
      end
      alm_pkg::ST_EXEC: begin
        // A running slot is never cut off by map writes
        if (exec_done) begin
          idx_d = next_slot(idx_q, final_q);
          st_d  = alm_pkg::ST_SCAN;
        end
      end
      default: st_d = alm_pkg::ST_IDLE;  // Code 2'b10 is illegal
    endcase
  end

  // Scanner registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q          <= alm_pkg::ST_IDLE;
      idx_q         <= 5'h00;
      sched_start_q <= 1'b0;
      sched_slot_q  <= 5'h00;
    end else begin
      st_q          <= st_d;
      idx_q         <= idx_d;
      sched_start_q <= start_d;
      sched_slot_q  <= slot_d;
    end
  end

  // Interrupt shaping and DMA polarity
  always_comb begin
    pcnt_d = (pcnt_q != 8'h00) ? pcnt_q - 8'h01 : 8'h00;
    // A new rising edge is ignored while a pulse is still running
    if (irq_event && !evt_q && pcnt_q == 8'h00) pcnt_d = IRQ_PULSE[7:0];
    irq_d = mode_q[alm_pkg::B_IRQ_EN] &&
            (mode_q[alm_pkg::B_IRQ_TRIG] ? (pcnt_q != 8'h00) : irq_event);
    irq_d  = irq_d ~^ mode_q[alm_pkg::B_IRQ_POL];
    ack_d  = dma_ack_input ~^ mode_q[alm_pkg::B_DMA_ACK_POLARITY];
    dma_request_output_d = dma_req ~^ mode_q[alm_pkg::B_DMA_REQUEST_POLARITY];
  end

  // Interrupt and DMA registers; reset levels match reset polarity zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pcnt_q               <= 8'h00;
      evt_q                <= 1'b0;
      irq_out_q            <= 1'b1;
      dma_ack_active_q     <= 1'b0;
      dma_request_output_q <= 1'b1;
    end else begin
      pcnt_q               <= pcnt_d;
      evt_q                <= irq_event;
      irq_out_q            <= irq_d;
      dma_ack_active_q     <= ack_d;
      dma_request_output_q <= dma_request_output_d;
    end
  end

  property p_done_set;
    @(posedge ref_clk) disable iff (!rstn)
    (st_q == alm_pkg::ST_EXEC && exec_done) |=> done_q[$past(sched_slot_q)];
  endproperty
  a_done_set: assert property (p_done_set) else $error("completion not flagged");

  property p_read_clear;
    @(posedge ref_clk) disable iff (!rstn)
    (rd_done && !exec_done) |=> (bus_rdata_q == $past(done_q)) && (done_q == 32'h00000000);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("done read not cleared");

  property p_skip;
    @(posedge ref_clk) disable iff (!rstn)
    (st_q == alm_pkg::ST_SCAN && skip_q[idx_q]) |=> !sched_start_q;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped slot started");

  property p_skip_wr;
    @(posedge ref_clk) disable iff (!rstn)
    (hit_skip && bus_req.wr) |=> skip_q == $past(bus_req.wdata);
  endproperty
  a_skip_wr: assert property (p_skip_wr) else $error("skip write lost");

  property p_wrap;
    @(posedge ref_clk) disable iff (!rstn)
    (st_q == alm_pkg::ST_SCAN && sched_enable && final_q[idx_q] &&
     !(slot_valid[idx_q] && !skip_q[idx_q])) |=> idx_q == 5'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("scan did not wrap");

  property p_mode_wr;
    @(posedge ref_clk) disable iff (!rstn)
    (hit_mode && bus_req.wr) |=> mode_q == ($past(bus_req.wdata) & alm_pkg::HWMODE_MASK);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write wrong");

  property p_irq_off;
    @(posedge ref_clk) disable iff (!rstn)
    !mode_q[alm_pkg::B_IRQ_EN] |=> irq_out_q != $past(mode_q[alm_pkg::B_IRQ_POL]);
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

  // Load value follows the parameter, so a shortened pulse is still checked correctly
  property p_pulse;
    @(posedge ref_clk) disable iff (!rstn)
    (irq_event && !evt_q && pcnt_q == 8'h00) |=> (pcnt_q == IRQ_PULSE[7:0]);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width wrong");

  // A running pulse counts down by one each cycle; new edges never reload it
  property p_pulse_dec;
    @(posedge ref_clk) disable iff (!rstn)
    (pcnt_q != 8'h00) |=> (pcnt_q == $past(pcnt_q) - 8'h01);
  endproperty
  a_pulse_dec: assert property (p_pulse_dec) else $error("pulse count wrong");

  property p_dma_request_output;
    @(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> dma_request_output_q == ($past(dma_req) ~^ $past(mode_q[alm_pkg::B_DMA_REQUEST_POLARITY]));
  endproperty
  a_dma_request_output: assert property (p_dma_request_output) else $error("dma_request_output polarity wrong");
endmodule

/* verif/alm_engine_model.sv */
// Purpose: Behavioural descriptor engine that answers scanner start pulses
// Assumes: One descriptor in flight at a time, start is a one-cycle pulse
// Notes:   Latency input lets a scenario answer promptly or slowly
module alm_engine_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       start,  // Start pulse from scanner
  input  wire logic [3:0] lat,    // Extra cycles before completion
  output logic            done    // One-cycle completion pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;   // Cycles left in current descriptor
  logic       busy;  // Descriptor in flight

  // Count down the latency, then report completion once
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cnt  <= lat;
      end else if (busy && cnt == 4'h0) begin
        done <= 1'b1;
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

/* verif/testbench.sv */
// Purpose: Self-checking bench for the async list maps and mode register
// Assumes: Inputs driven at the falling edge, design samples on the rising edge
// Notes:   Pulse width shortened by parameter so the run stays brief
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PULSE = 4;  // Shortened interrupt pulse width
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
  } alm_row_t;
  logic                  ref_clk = 1'b0;
  logic                  rstn = 1'b0;
  alm_pkg::alm_bus_req_t bus_req = '0;
  logic                  sched_enable = 1'b0;
  logic [31:0]           slot_valid = 32'h0;
  logic                  irq_event = 1'b0;
  logic                  dma_ack_in = 1'b0;
  logic                  dma_req = 1'b0;
  logic [31:0]           rdata;
  logic                  rvalid, start, exec_done, irq_out, dma_ack_input_act, dma_request_output_out;
  logic                  xcvr, oc, bus32;
  logic [4:0]            slot;
  logic [31:0]           rd_v;
  int                    error_cnt = 0;
  int                    checks_done = 0;
  int                    cyc = 0;
  int                    n;
  logic [4:0]            starts[$];  // Slots in the order they were started
  // Reset values, access kinds and a refused write; write first when wr is set
  alm_row_t rows[10] = '{
    '{1'b0, 12'h150, 32'h0, 32'h00000000}, '{1'b0, 12'h154, 32'h0, 32'hffffffff},
    '{1'b0, 12'h158, 32'h0, 32'h00000000}, '{1'b0, 12'h300, 32'h0, 32'h00000100},
    '{1'b1, 12'h150, 32'hffffffff, 32'h0}, '{1'b1, 12'h154, 32'ha5a5a5a5, 32'ha5a5a5a5},
    '{1'b1, 12'h158, 32'h4, 32'h4},        '{1'b1, 12'h300, 32'h80008167, 32'h80008167},
    '{1'b1, 12'h300, 32'h0, 32'h0},        '{1'b0, 12'h304, 32'h0, 32'h0}};

  always #2.5 ref_clk = ~ref_clk;

  alm_async_list_maps #(.IRQ_PULSE(PULSE)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata_q(rdata),
    .bus_rvalid_q(rvalid), .sched_enable(sched_enable), .slot_valid(slot_valid),
    .sched_start_q(start), .sched_slot_q(slot), .exec_done(exec_done),
    .irq_event(irq_event), .irq_out_q(irq_out), .dma_ack_input(dma_ack_in),
    .dma_ack_active_q(dma_ack_input_act), .dma_req(dma_req), .dma_request_output_q(dma_request_output_out),
    .all_transceiver_reset_q(xcvr), .overcurrent_type_select_q(oc), .bus_is_32bit_q(bus32));

  alm_engine_model engine_u (
    .ref_clk(ref_clk), .rstn(rstn), .start(start), .lat(4'h3), .done(exec_done));

  // Log every start pulse; the registered pulse is seen as it stood before the edge
  always @(posedge ref_clk) begin
    if (start === 1'b1) starts.push_back(slot);
  end

  // Hang guard, well above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge ref_clk) bus_req = '{1'b1, 1'b1, 1'b0, a, d};
    @(negedge ref_clk) bus_req = '0;
  endtask

  // Read data is registered, so it stands at the falling edge after the strobe
  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
    @(negedge ref_clk) bus_req = '{1'b1, 1'b0, 1'b1, a, 32'h0};
    @(negedge ref_clk) bus_req = '0;
    check(32'(rvalid), 32'h1);
    d = rdata;
  endtask

  task automatic mode_chk(input logic [31:0] m, input logic [31:0] exp);
    bus_wr(alm_pkg::OFS_HWMODE, m);
    repeat (3) @(negedge ref_clk);
    check({26'h0, xcvr, oc, bus32, dma_ack_input_act, dma_request_output_out, irq_out}, exp);
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    // Every slot is skipped after reset, so nothing may start
    slot_valid = 32'hffffffff;
    sched_enable = 1'b1;
    repeat (40) @(negedge ref_clk);
    sched_enable = 1'b0;
    check(starts.size(), 32'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) bus_wr(rows[i].addr, rows[i].data);
      bus_rd(rows[i].addr, rd_v);
      check(rd_v, rows[i].exp);
    end
    // Slot 1 valid but skipped, slot 3 valid and runnable but past the final slot
    bus_wr(alm_pkg::OFS_SKIP, 32'hfffffff2);
    bus_wr(alm_pkg::OFS_FINAL, 32'h00000004);
    slot_valid = 32'h0000000f;
    starts.delete();
    sched_enable = 1'b1;
    for (n = 0; n < 200 && starts.size() < 4; n++) @(negedge ref_clk);
    sched_enable = 1'b0;
    repeat (20) @(negedge ref_clk);
    check({starts[0], starts[1], starts[2], starts[3]}, 20'h00802);
    bus_rd(alm_pkg::OFS_DONE, rd_v);
    check(rd_v, 32'h00000005);
    bus_rd(alm_pkg::OFS_DONE, rd_v);
    check(rd_v, 32'h0);
    // Mode pins: {xcvr, oc, bus32, ack, request pin, irq pin}
    irq_event = 1'b1;
    dma_req = 1'b1;
    dma_ack_in = 1'b1;
    // Reserved mode bits are always written as zero from here on
    mode_chk(32'h00000000, 32'h01);
    mode_chk(32'h00000001, 32'h00);
    mode_chk(32'h00000045, 32'h05);
    mode_chk(32'h80008120, 32'h3b);
    irq_event = 1'b0;
    mode_chk(32'h00000007, 32'h00);
    irq_event = 1'b1;
    n = 0;
    repeat (20) @(negedge ref_clk) n += (irq_out === 1'b1);
    check(n, PULSE);
    // Second reset in mid-run brings the mode register back
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    bus_rd(alm_pkg::OFS_HWMODE, rd_v);
    check(rd_v, alm_pkg::RST_HWMODE);
    finish_test();
  end
endmodule
